// file: rtl/scc_pkg.sv
package scc_pkg;

    // ========================================
    // Sizes
    localparam int unsigned NUM_CH = 8;
    localparam int unsigned CH_W = 3;
    localparam int unsigned SPAN_W = 3;
    localparam int unsigned CODE_W = 16;
    localparam int unsigned SEQ_DEPTH = 8;
    localparam int unsigned SEQ_IDX_W = 3;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned BIT_IDX_W = 4;

    // ========================================
    // Register byte offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_MANUAL = 8'h04;
    localparam logic [ADDR_W-1:0] REG_SEQ_LEN = 8'h08;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_RESULT = 8'h10;
    localparam logic [ADDR_W-1:0] REG_SPAN_BASE = 8'h20;
    localparam logic [ADDR_W-1:0] REG_SEQ_BASE = 8'h40;

    // ========================================
    // Field positions
    localparam int unsigned CTRL_SEQ_EN_BIT = 0;
    localparam int unsigned CTRL_PWR_LSB = 1;
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_READY_BIT = 1;
    localparam int unsigned STAT_STATE_LSB = 4;
    localparam int unsigned STAT_CH_LSB = 8;
    localparam int unsigned STAT_SPAN_LSB = 12;
    localparam int unsigned STAT_SEQ_IDX_LSB = 16;
    localparam int unsigned RES_SPAN_LSB = 16;
    localparam int unsigned SEQ_SPAN_LSB = 4;

    // ========================================
    // Values after reset and at search start
    localparam logic [SPAN_W-1:0] SPAN_RST = 3'h7;
    localparam logic [CH_W-1:0] MANUAL_RST = 3'h0;
    localparam logic [SEQ_IDX_W-1:0] SEQ_LEN_RST = 3'h7;
    localparam logic [CODE_W-1:0] CODE_RST = 16'h0000;
    localparam logic [CODE_W-1:0] SAR_MSB = 16'h8000;
    localparam logic [BIT_IDX_W-1:0] SAR_TOP_IDX = 4'hF;

    // Code step for span 7 on the nominal reference, in nanovolts
    localparam int unsigned SPAN7_FSR_UV = 20480000;
    localparam int unsigned SPAN7_LSB_NV = 312500;
    localparam int unsigned SAR_CYCLES = 16;

    // ========================================
    // Enumerations
    typedef enum logic [1:0] {
        PWR_RUN = 2'b00,
        PWR_NAP = 2'b01,
        PWR_DOWN = 2'b10
    } scc_pwr_t;

    typedef enum logic [2:0] {
        ST_ACQ = 3'b000,
        ST_CONV = 3'b001,
        ST_CLEAR = 3'b010,
        ST_NAP = 3'b011,
        ST_PDOWN = 3'b100
    } scc_state_t;

    // Bipolar span codes all have bit 1 set (7, 6, 3, 2)
    function automatic logic span_is_bipolar(input logic [SPAN_W-1:0] span);
        return span[1];
    endfunction

    // Search result is offset binary; bipolar spans flip the sign bit
    function automatic logic [CODE_W-1:0] format_code(input logic [CODE_W-1:0] raw,
                                                      input logic [SPAN_W-1:0] span);
        if (span_is_bipolar(span))
        begin
            return {~raw[CODE_W-1], raw[CODE_W-2:0]};
        end
        return raw;
    endfunction

endpackage

// file: rtl/scc_sar_engine.sv
module scc_sar_engine
    import scc_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Control
    input wire logic start_i,
    output logic busy_o,
    output logic done_o,
    // Trial code to the capacitor DAC and comparator answer
    output logic [CODE_W-1:0] dac_code_o,
    input wire logic comp_i,
    // Final offset-binary code
    output logic [CODE_W-1:0] code_o
);

    logic [CODE_W-1:0] code_q;
    logic [BIT_IDX_W-1:0] idx_q;
    logic busy_q;
    logic done_q;

    // ========================================
    // Search: one trial bit per cycle, MSB first; comp_i high keeps the bit
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            code_q <= CODE_RST;
            idx_q <= SAR_TOP_IDX;
        end
        else if (start_i && !busy_q)
        begin
            code_q <= SAR_MSB;
            idx_q <= SAR_TOP_IDX;
        end
        else if (busy_q)
        begin
            if (!comp_i)
            begin
                code_q[idx_q] <= 1'b0;
            end
            if (idx_q != '0)
            begin
                code_q[idx_q - 4'h1] <= 1'b1;
                idx_q <= idx_q - 4'h1;
            end
        end
    end

    // Busy spans exactly the sixteen compare cycles
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= busy_q && (idx_q == '0);
            if (start_i && !busy_q)
            begin
                busy_q <= 1'b1;
            end
            else if (busy_q && (idx_q == '0))
            begin
                busy_q <= 1'b0;
            end
        end
    end

    assign busy_o = busy_q;
    assign done_o = done_q;
    assign dac_code_o = code_q;
    assign code_o = code_q;

    // ========================================
    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_started;
        start_i && !busy_q;
    endsequence

    // Sixteen busy cycles are counted as two runs of eight
    a_sar_length: assert property (s_started |-> ##1 busy_q [*8] ##1 busy_q [*8]
                                   ##1 done_q)
        else $error("search did not take sixteen cycles");
    a_sar_msb_first: assert property (s_started |=> dac_code_o == SAR_MSB)
        else $error("search did not open at half scale");
    a_sar_keep_bit: assert property (busy_q && comp_i |=> code_q[$past(idx_q)])
        else $error("accepted trial bit was dropped");

endmodule

// file: rtl/scc_sequencer.sv
module scc_sequencer
    import scc_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Entry programming
    input wire logic wr_en_i,
    input wire logic [SEQ_IDX_W-1:0] wr_idx_i,
    input wire logic [CH_W-1:0] wr_chan_i,
    input wire logic [SPAN_W-1:0] wr_span_i,
    input wire logic [SEQ_IDX_W-1:0] last_idx_i,
    // Stepping
    input wire logic restart_i,
    input wire logic advance_i,
    // Current entry and readback
    output logic [CH_W-1:0] chan_o,
    output logic [SPAN_W-1:0] span_o,
    output logic [SEQ_IDX_W-1:0] idx_o,
    input wire logic [SEQ_IDX_W-1:0] rd_idx_i,
    output logic [CH_W+SPAN_W-1:0] rd_entry_o
);

    logic [CH_W-1:0] chan_mem_q [SEQ_DEPTH];
    logic [SPAN_W-1:0] span_mem_q [SEQ_DEPTH];
    logic [SEQ_IDX_W-1:0] idx_q;

    // ========================================
    // Entry table; resets to channel i on the widest bipolar span
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < SEQ_DEPTH; i++)
            begin
                chan_mem_q[i] <= CH_W'(i);
                span_mem_q[i] <= SPAN_RST;
            end
        end
        else if (wr_en_i)
        begin
            chan_mem_q[wr_idx_i] <= wr_chan_i;
            span_mem_q[wr_idx_i] <= wr_span_i;
        end
    end

    // Wraps after the last programmed entry
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i || restart_i)
        begin
            idx_q <= '0;
        end
        else if (advance_i)
        begin
            idx_q <= (idx_q >= last_idx_i) ? '0 : idx_q + 3'h1;
        end
    end

    assign chan_o = chan_mem_q[idx_q];
    assign span_o = span_mem_q[idx_q];
    assign idx_o = idx_q;
    assign rd_entry_o = {span_mem_q[rd_idx_i], chan_mem_q[rd_idx_i]};

    // ========================================
    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    a_seq_wrap: assert property (advance_i && !restart_i && idx_q >= last_idx_i
                                 |=> idx_q == '0)
        else $error("sequencer did not wrap");

endmodule

// file: rtl/scc_top.sv
module scc_top
    import scc_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Conversion trigger from the host
    input wire logic convert_start_i,
    // Analog front end control
    output logic [NUM_CH-1:0] track_o,
    output logic sample_clear_o,
    output logic [CH_W-1:0] mux_sel_o,
    output logic [SPAN_W-1:0] span_o,
    output logic [CODE_W-1:0] charge_redistribution_dac_o,
    input wire logic comp_i,
    output logic nap_o,
    output logic power_down_o,
    // Result toward the serial interface
    output logic [CODE_W-1:0] result_o,
    output logic [SPAN_W-1:0] result_span_o,
    output logic result_ready_o,
    output logic busy_o
);

    scc_state_t state_q;
    logic start_prev_q;
    logic cnv_edge;
    logic eng_start;
    logic eng_busy;
    logic eng_done;
    logic [CODE_W-1:0] eng_code;
    logic seq_en_q;
    logic [1:0] pwr_q;
    logic [CH_W-1:0] manual_q;
    logic [SEQ_IDX_W-1:0] seq_last_q;
    logic [SPAN_W-1:0] per_conversion_span_q [NUM_CH];
    logic [CH_W-1:0] conv_ch_q;
    logic [SPAN_W-1:0] conv_span_q;
    logic [CODE_W-1:0] result_q;
    logic [SPAN_W-1:0] result_span_q;
    logic ready_q;
    logic [CH_W-1:0] seq_chan;
    logic [SPAN_W-1:0] seq_span;
    logic [SEQ_IDX_W-1:0] seq_idx;
    logic [CH_W+SPAN_W-1:0] seq_rd_entry;
    logic wb_req;
    logic wb_wr;
    logic wb_rd;
    logic ack_q;
    logic [31:0] dat_q;
    logic seq_wr;
    logic span_wr;
    logic result_read;
    logic [CH_W-1:0] next_ch;
    logic [SPAN_W-1:0] next_span;

    // ========================================
    // Wishbone decode; a request is taken in the cycle ack rises
    assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];
    assign wb_rd = wb_req && !wb_we_i;
    assign seq_wr = wb_wr && (wb_adr_i[7:5] == REG_SEQ_BASE[7:5]) && (wb_adr_i[1:0] == 2'b00);
    assign span_wr = wb_wr && (wb_adr_i[7:5] == REG_SPAN_BASE[7:5]) && (wb_adr_i[1:0] == 2'b00);
    assign result_read = wb_rd && (wb_adr_i == REG_RESULT);

    // One wait state: ack follows the request by one edge and drops after
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= wb_req;
        end
    end

    // Control registers
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            seq_en_q <= 1'b0;
            pwr_q <= PWR_RUN;
            manual_q <= MANUAL_RST;
            seq_last_q <= SEQ_LEN_RST;
        end
        else if (wb_wr)
        begin
            unique case (wb_adr_i)
                REG_CTRL:
                begin
                    seq_en_q <= wb_dat_i[CTRL_SEQ_EN_BIT];
                    pwr_q <= wb_dat_i[CTRL_PWR_LSB +: 2];
                end
                REG_MANUAL: manual_q <= wb_dat_i[CH_W-1:0];
                REG_SEQ_LEN: seq_last_q <= wb_dat_i[SEQ_IDX_W-1:0];
                default: ;
            endcase
        end
    end

    // Span code held per channel; widest bipolar span after reset
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                per_conversion_span_q[i] <= SPAN_RST;
            end
        end
        else if (span_wr)
        begin
            per_conversion_span_q[wb_adr_i[4:2]] <= wb_dat_i[SPAN_W-1:0];
        end
    end

    // Registered read data; unmapped addresses read as zero
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            dat_q <= 32'h0000_0000;
        end
        else if (wb_rd)
        begin
            dat_q <= 32'h0000_0000;
            if (wb_adr_i == REG_CTRL)
            begin
                dat_q[CTRL_SEQ_EN_BIT] <= seq_en_q;
                dat_q[CTRL_PWR_LSB +: 2] <= pwr_q;
            end
            else if (wb_adr_i == REG_MANUAL)
            begin
                dat_q[CH_W-1:0] <= manual_q;
            end
            else if (wb_adr_i == REG_SEQ_LEN)
            begin
                dat_q[SEQ_IDX_W-1:0] <= seq_last_q;
            end
            else if (wb_adr_i == REG_STATUS)
            begin
                dat_q[STAT_BUSY_BIT] <= (state_q != ST_ACQ);
                dat_q[STAT_READY_BIT] <= ready_q;
                dat_q[STAT_STATE_LSB +: 3] <= state_q;
                dat_q[STAT_CH_LSB +: CH_W] <= conv_ch_q;
                dat_q[STAT_SPAN_LSB +: SPAN_W] <= conv_span_q;
                dat_q[STAT_SEQ_IDX_LSB +: SEQ_IDX_W] <= seq_idx;
            end
            else if (wb_adr_i == REG_RESULT)
            begin
                dat_q[CODE_W-1:0] <= result_q;
                dat_q[RES_SPAN_LSB +: SPAN_W] <= result_span_q;
            end
            else if (wb_adr_i[7:5] == REG_SPAN_BASE[7:5] && wb_adr_i[1:0] == 2'b00)
            begin
                dat_q[SPAN_W-1:0] <= per_conversion_span_q[wb_adr_i[4:2]];
            end
            else if (wb_adr_i[7:5] == REG_SEQ_BASE[7:5] && wb_adr_i[1:0] == 2'b00)
            begin
                dat_q[CH_W-1:0] <= seq_rd_entry[CH_W-1:0];
                dat_q[SEQ_SPAN_LSB +: SPAN_W] <= seq_rd_entry[CH_W +: SPAN_W];
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // ========================================
    // Trigger edge detect; convert_start is synchronous to clock_i
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            start_prev_q <= 1'b0;
        end
        else
        begin
            start_prev_q <= convert_start_i;
        end
    end

    assign cnv_edge = convert_start_i && !start_prev_q;
    // Edges outside acquisition are dropped, including in the clear cycle when ready rises; the host must wait for busy to fall
    assign eng_start = cnv_edge && (state_q == ST_ACQ);

    // Channel and span for the next conversion
    assign next_ch = seq_en_q ? seq_chan : manual_q;
    assign next_span = seq_en_q ? seq_span : per_conversion_span_q[manual_q];

    // ========================================
    // Phase control: acquire, convert, clear the held sample, low power
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= ST_ACQ;
        end
        else
        begin
            unique case (state_q)
                ST_ACQ:
                begin
                    if (eng_start)
                    begin
                        state_q <= ST_CONV;
                    end
                    else if (pwr_q == PWR_NAP)
                    begin
                        state_q <= ST_NAP;
                    end
                    else if (pwr_q != PWR_RUN)
                    begin
                        state_q <= ST_PDOWN;
                    end
                end
                ST_CONV:
                begin
                    if (eng_done)
                    begin
                        state_q <= ST_CLEAR;
                    end
                end
                ST_CLEAR: state_q <= ST_ACQ;
                ST_NAP, ST_PDOWN:
                begin
                    if (pwr_q == PWR_RUN)
                    begin
                        state_q <= ST_ACQ;
                    end
                end
                default: state_q <= ST_ACQ;
            endcase
        end
    end

    // Settings latched at the edge so later writes cannot disturb a conversion
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            conv_ch_q <= MANUAL_RST;
            conv_span_q <= SPAN_RST;
        end
        else if (eng_start)
        begin
            conv_ch_q <= next_ch;
            conv_span_q <= next_span;
        end
    end

    // Result capture and coding per span
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            result_q <= CODE_RST;
            result_span_q <= SPAN_RST;
        end
        else if (eng_done && state_q == ST_CONV)
        begin
            result_q <= format_code(eng_code, conv_span_q);
            result_span_q <= conv_span_q;
        end
    end

    // Ready flag: a finishing conversion wins over a read of the result
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            ready_q <= 1'b0;
        end
        else if (eng_done && state_q == ST_CONV)
        begin
            ready_q <= 1'b1;
        end
        else if (result_read || eng_start)
        begin
            ready_q <= 1'b0;
        end
    end

    // ========================================
    // Submodules
    scc_sar_engine u_sar
    (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .start_i(eng_start),
        .busy_o(eng_busy),
        .done_o(eng_done),
        .dac_code_o(charge_redistribution_dac_o),
        .comp_i(comp_i),
        .code_o(eng_code)
    );

    scc_sequencer u_seq
    (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .wr_en_i(seq_wr),
        .wr_idx_i(wb_adr_i[4:2]),
        .wr_chan_i(wb_dat_i[CH_W-1:0]),
        .wr_span_i(wb_dat_i[SEQ_SPAN_LSB +: SPAN_W]),
        .last_idx_i(seq_last_q),
        .restart_i(wb_wr && wb_adr_i == REG_CTRL),
        .advance_i(eng_start && seq_en_q),
        .chan_o(seq_chan),
        .span_o(seq_span),
        .idx_o(seq_idx),
        .rd_idx_i(wb_adr_i[4:2]),
        .rd_entry_o(seq_rd_entry)
    );

    // Outputs to the front end
    assign track_o = {NUM_CH{state_q == ST_ACQ}};
    assign sample_clear_o = (state_q == ST_CLEAR);
    assign mux_sel_o = conv_ch_q;
    assign span_o = conv_span_q;
    assign nap_o = (state_q == ST_NAP);
    assign power_down_o = (state_q == ST_PDOWN);
    assign result_o = result_q;
    assign result_span_o = result_span_q;
    assign result_ready_o = ready_q;
    assign busy_o = (state_q != ST_ACQ);

    // ========================================
    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_conv_done;
        eng_done && state_q == ST_CONV;
    endsequence

    a_track_idle: assert property (state_q == ST_ACQ |-> track_o == {NUM_CH{1'b1}})
        else $error("idle channels not tracking");
    a_hold_on_edge: assert property (eng_start |=> track_o == '0 && state_q == ST_CONV)
        else $error("start edge did not hold the samples");
    a_conv_time: assert property (eng_start |=> (state_q == ST_CONV) [*8]
                                  ##1 (state_q == ST_CONV) [*8] ##1 eng_done)
        else $error("conversion length wrong");
    a_clear_after: assert property (s_conv_done |=> sample_clear_o ##1 state_q == ST_ACQ)
        else $error("held sample not cleared");
    a_ready_set: assert property (s_conv_done |=> result_ready_o)
        else $error("result not flagged ready");
    a_bipolar_fmt: assert property (eng_done && state_q == ST_CONV && span_is_bipolar(conv_span_q)
                                    |=> result_o[15] == !$past(eng_code[15]))
        else $error("bipolar result not two's complement");
    a_unipolar_fmt: assert property (eng_done && state_q == ST_CONV && !span_is_bipolar(conv_span_q)
                                     |=> result_o == $past(eng_code))
        else $error("unipolar result not straight binary");
    a_span_latch: assert property (eng_start && !seq_en_q
                                   |=> span_o == $past(per_conversion_span_q[manual_q]))
        else $error("conversion span not taken from channel");
    a_power_idle: assert property (nap_o || power_down_o |-> !eng_busy)
        else $error("low power entered during conversion");
    a_wb_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

endmodule

// file: tb/scc_front_model.sv
module scc_front_model
(
    // Clock
    input wire logic clock_i,
    // Front end control from the block
    input wire logic [7:0] track_i,
    input wire logic sample_clear_i,
    input wire logic [2:0] mux_i,
    input wire logic [15:0] dac_i,
    // Channel levels as offset-binary codes
    input wire logic [15:0] vin_i [8],
    // Comparator answer
    output logic comp_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] held_q [8];

    // Each channel follows its input while tracking; a clear scrambles the hold
    // so a stale sample can never pass for a fresh one
    always_ff @(posedge clock_i)
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (track_i[i])
                held_q[i] <= vin_i[i];
            else if (sample_clear_i)
                held_q[i] <= ~held_q[i];
        end
    end

    // High while the held sample is at or above the trial code
    assign comp_o = (held_q[mux_i] >= dac_i);
endmodule

// file: tb/tb_top.sv
module tb_top
    import scc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================
    // Signals
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_we = 1'b0;
    logic [3:0] wb_sel = 4'hF;
    logic [ADDR_W-1:0] wb_adr = 8'h00;
    logic [31:0] wb_wdat = 32'h0000_0000;
    logic [31:0] wb_rdat, rv;
    logic wb_ack, convert_start = 1'b0, comp, sclr, rdy, busy, nap, pdn;
    logic [7:0] track;
    logic [2:0] mux, span, rspan;
    logic [15:0] dac, res;
    logic [15:0] vin [8] = '{default: 16'h0000};
    int error_cnt = 0;
    int num_checks = 0;
    int seed = 75886;
    int cyc_cnt = 0;
    logic [18:0] exp_q [$];

    always #2 clock_i = ~clock_i;

    scc_top dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_cyc),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .convert_start_i(convert_start), .track_o(track),
        .sample_clear_o(sclr), .mux_sel_o(mux), .span_o(span),
        .charge_redistribution_dac_o(dac), .comp_i(comp), .nap_o(nap), .power_down_o(pdn),
        .result_o(res), .result_span_o(rspan), .result_ready_o(rdy), .busy_o(busy));

    scc_front_model fe (.clock_i(clock_i), .track_i(track), .sample_clear_i(sclr),
        .mux_i(mux), .dac_i(dac), .vin_i(vin), .comp_o(comp));

    // ========================================
    // Checks and bus access
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %0t register got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic [18:0] got, input logic [18:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %0t output got %h want %h", $time, got, exp);
        end
    endtask

    // Classic cycle: hold everything until ack is sampled, then release for a cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
        wb_cyc <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_wdat <= d;
        wb_sel <= s;
        // No cycle count is assumed; only the hang guard ends the wait
        do
        begin
            @(posedge clock_i);
        end
        while (wb_ack !== 1'b1);
        q = wb_rdat;
        wb_cyc <= 1'b0;
        @(posedge clock_i);
    endtask

    // One conversion against the queue model; optional second edge mid-run
    task automatic conv(input logic [2:0] ch, input logic [2:0] sp, input bit twice);
        logic [15:0] v;
        for (int i = 0; i < 8; i++)
            vin[i] <= 16'($random(seed));
        @(posedge clock_i);
        v = vin[ch];
        exp_q.push_back({sp, sp[1] ? (v ^ 16'h8000) : v});
        convert_start <= 1'b1;
        repeat (4) @(posedge clock_i);
        chk_out(19'(track), 19'h0);
        // Optional stray edge mid-conversion probes that it is ignored
        if (twice)
        begin
            convert_start <= 1'b0;
            @(posedge clock_i);
            convert_start <= 1'b1;
        end
        while (rdy !== 1'b1)
        begin
            @(posedge clock_i);
        end
        chk_out({rspan, res}, exp_q[0]);
        chk_out(19'(sclr), 19'h1);
        chk_out({13'h0, mux, span}, {13'h0, ch, sp});
        wb(1'b0, REG_RESULT, 32'h0, 4'hF, rv);
        chk_reg(rv, 32'(exp_q.pop_front()));
        chk_out({10'h0, rdy, track}, {10'h0, 1'b0, 8'hFF});
        convert_start <= 1'b0;
        repeat (2) @(posedge clock_i);
    endtask

    // ========================================
    // Hang guard, far above the few hundred cycles a clean run needs
    always @(posedge clock_i)
    begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 3000)
        begin
            error_cnt++;
            print_verdict();
        end
    end

    // Main sequence
    initial
    begin
        repeat (4) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(posedge clock_i);
        wb(1'b1, REG_SEQ_LEN, 32'h0000_0001, 4'hE, rv);
        wb(1'b0, REG_SEQ_LEN, 32'h0, 4'hF, rv);
        chk_reg(rv, 32'h0000_0007);
        wb(1'b0, REG_SPAN_BASE + 8'h1C, 32'h0, 4'hF, rv);
        chk_reg(rv, 32'h0000_0007);
        wb(1'b0, 8'h80, 32'h0, 4'hF, rv);
        chk_reg(rv, 32'h0000_0000);
        $display("test registers done");
        for (int s = 0; s < 8; s++)
        begin
            wb(1'b1, REG_SPAN_BASE + 8'(4 * s), 32'(s), 4'hF, rv);
            wb(1'b1, REG_MANUAL, 32'(s), 4'hF, rv);
            conv(3'(s), 3'(s), s == 3);
        end
        $display("test spans done");
        wb(1'b1, REG_SEQ_BASE, 32'h0000_0052, 4'hF, rv);
        wb(1'b1, REG_SEQ_BASE + 8'h04, 32'h0000_0026, 4'hF, rv);
        wb(1'b1, REG_SEQ_LEN, 32'h0000_0001, 4'hF, rv);
        wb(1'b1, REG_CTRL, 32'h0000_0001, 4'hF, rv);
        conv(3'h2, 3'h5, 1'b0);
        conv(3'h6, 3'h2, 1'b0);
        conv(3'h2, 3'h5, 1'b0);
        $display("test sequencer done");
        wb(1'b1, REG_CTRL, 32'h0000_0002, 4'hF, rv);
        @(posedge clock_i);
        chk_out({16'h0, nap, pdn, busy}, 19'h5);
        // Nap only returns to acquisition, so power-down is entered from run
        wb(1'b1, REG_CTRL, 32'h0000_0000, 4'hF, rv);
        wb(1'b1, REG_CTRL, 32'h0000_0004, 4'hF, rv);
        @(posedge clock_i);
        chk_out({16'h0, nap, pdn, busy}, 19'h3);
        wb(1'b1, REG_CTRL, 32'h0000_0000, 4'hF, rv);
        @(posedge clock_i);
        chk_out({8'h0, nap, pdn, busy, track}, {11'h0, 8'hFF});
        $display("test power done");
        print_verdict();
    end
endmodule
